// ==== rtl/bbcp_duty_div.sv ====
// Serial divider turning high and total sample counts into an 11-bit duty code
`timescale 1ns/1ps
module bbcp_duty_div #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Request
  input wire logic start_in,
  input wire logic [CNT_W-1:0] high_in,
  input wire logic [CNT_W-1:0] total_in,
  // Answer
  output logic busy_out,
  output logic done_out,
  output logic [10:0] code_out
);

  bbcp_pkg::bbcp_div_state_e state_q;
  logic [CNT_W:0] rem_q;
  logic [CNT_W:0] den_q;
  logic [11:0] quo_q;
  logic [3:0] bit_q;
  logic [CNT_W:0] rem_sh;
  logic ge;
  logic [11:0] quo_fin;

  if (CNT_W < 8 || CNT_W > 24)
  begin : g_chk
    $error("CNT_W out of range");
  end

  // First step compares the count itself, later steps shift the remainder
  always_comb
  begin
    rem_sh = (bit_q == 4'h0) ? rem_q : {rem_q[CNT_W-1:0], 1'b0};
    ge = (rem_sh >= den_q);
    quo_fin = {quo_q[10:0], ge};
  end

  // Restoring division, twelve quotient bits
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      state_q <= bbcp_pkg::BBCP_DIV_IDLE;
      rem_q <= '0;
      den_q <= '0;
      quo_q <= 12'h000;
      bit_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        bbcp_pkg::BBCP_DIV_IDLE:
        begin
          if (start_in && total_in != '0)
          begin
            rem_q <= {1'b0, high_in};
            den_q <= {1'b0, total_in};
            quo_q <= 12'h000;
            bit_q <= 4'h0;
            state_q <= bbcp_pkg::BBCP_DIV_RUN;
          end
        end
        bbcp_pkg::BBCP_DIV_RUN:
        begin
          rem_q <= ge ? rem_sh - den_q : rem_sh;
          quo_q <= quo_fin;
          bit_q <= bit_q + 4'h1;
          if (bit_q == 4'hb)
          begin
            state_q <= bbcp_pkg::BBCP_DIV_IDLE;
          end
        end
        default:
        begin
          state_q <= bbcp_pkg::BBCP_DIV_IDLE;
        end
      endcase
    end
  end

  // Result with saturation of a full-scale quotient
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      done_out <= 1'b0;
      code_out <= bbcp_pkg::CODE_RESET;
    end
    else
    begin
      done_out <= (state_q == bbcp_pkg::BBCP_DIV_RUN) && (bit_q == 4'hb);
      if (state_q == bbcp_pkg::BBCP_DIV_RUN && bit_q == 4'hb)
      begin
        code_out <= quo_fin[11] ? bbcp_pkg::CODE_MAX : quo_fin[10:0];
      end
    end
  end

  assign busy_out = (state_q != bbcp_pkg::BBCP_DIV_IDLE);

endmodule

// ==== rtl/bbcp_pkg.sv ====
// Shared constants and types for the backlight brightness code path
package bbcp_pkg;

  // ----------------------------------------------------------------
  // Clock and code widths
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 250_000_000;
  localparam int CODE_W = 11;
  localparam logic [10:0] CODE_MAX = 11'h7ff;
  localparam logic [10:0] CODE_RESET = 11'h000;
  localparam logic [2:0] LOW_RESET = 3'h0;

  // ----------------------------------------------------------------
  // PWM sample rates, selected by a 2-bit field (0, 1, 1x)
  // ----------------------------------------------------------------
  localparam int SR_HZ_SLOW = 800_000;
  localparam int SR_HZ_MID = 4_000_000;
  localparam int SR_HZ_FAST = 24_000_000;
  localparam int SR_DIV_SLOW = CLK_HZ / SR_HZ_SLOW;
  localparam int SR_DIV_MID = CLK_HZ / SR_HZ_MID;
  localparam int SR_DIV_FAST = CLK_HZ / SR_HZ_FAST;

  // ----------------------------------------------------------------
  // PWM-loss timeout per sample rate, in us and in sample ticks
  // ----------------------------------------------------------------
  localparam int TO_US_SLOW = 25_000;
  localparam int TO_US_MID = 3_000;
  localparam int TO_US_FAST = 600;
  localparam int TO_SMP_SLOW = TO_US_SLOW * (SR_HZ_SLOW / 1000) / 1000;
  localparam int TO_SMP_MID = TO_US_MID * (SR_HZ_MID / 1000) / 1000;
  localparam int TO_SMP_FAST = TO_US_FAST * (SR_HZ_FAST / 1000) / 1000;

  // ----------------------------------------------------------------
  // Ramp step times in us, one per 3-bit ramp rate code
  // ----------------------------------------------------------------
  localparam int US_DIV = CLK_HZ / 1_000_000;
  localparam int RAMP_US [8] = '{1, 2, 4, 8, 16, 64, 256, 1000};
  localparam int RAMP_US_W = 10;

  // ----------------------------------------------------------------
  // Hysteresis field
  // ----------------------------------------------------------------
  localparam logic [2:0] HYST_MAX = 3'h6;

  // ----------------------------------------------------------------
  // Brightness control modes and divider states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BBCP_MODE_I2C = 2'h0,
    BBCP_MODE_PWM = 2'h1,
    BBCP_MODE_MUL_AFTER = 2'h2,
    BBCP_MODE_MUL_BEFORE = 2'h3
  } bbcp_mode_e;

  typedef enum logic {
    BBCP_DIV_IDLE = 1'b0,
    BBCP_DIV_RUN = 1'b1
  } bbcp_div_state_e;

endpackage

// ==== rtl/bbcp_top.sv ====
// Backlight brightness code path: PWM duty measure, hysteresis, mode mix and ramper
`timescale 1ns/1ps
module bbcp_top #(
  parameter int CNT_W = 16,
  parameter int TO_SMP_SLOW = bbcp_pkg::TO_SMP_SLOW,
  parameter int TO_SMP_MID = bbcp_pkg::TO_SMP_MID,
  parameter int TO_SMP_FAST = bbcp_pkg::TO_SMP_FAST
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // PWM pin
  input wire logic pwm_in,
  // Brightness word writes
  input wire logic [2:0] brightness_low_in,
  input wire logic brightness_low_wr_in,
  input wire logic [7:0] brightness_high_in,
  input wire logic brightness_high_wr_in,
  // Configuration
  input wire logic [1:0] mode_in,
  input wire logic [1:0] sample_rate_in,
  input wire logic [2:0] hysteresis_in,
  input wire logic [2:0] ramp_rate_in,
  // Status and code
  output logic [10:0] brightness_code_out,
  output logic [10:0] pwm_code_out,
  output logic led_on_out,
  output logic boost_on_out,
  output logic pwm_timeout_out
);

  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_SAT = '1;

  if (TO_SMP_SLOW >= 2 ** CNT_W || TO_SMP_MID >= 2 ** CNT_W || TO_SMP_FAST >= 2 ** CNT_W || TO_SMP_FAST < 1)
  begin : g_chk
    $error("Timeout counts do not fit CNT_W");
  end

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [8:0] sr_div(input logic [1:0] r);
    logic [8:0] v;
    v = 9'(bbcp_pkg::SR_DIV_FAST - 1);
    if (r == 2'h0) v = 9'(bbcp_pkg::SR_DIV_SLOW - 1);
    else if (r == 2'h1) v = 9'(bbcp_pkg::SR_DIV_MID - 1);
    return v;
  endfunction

  function automatic logic [CNT_W-1:0] to_limit(input logic [1:0] r);
    logic [CNT_W-1:0] v;
    v = CNT_W'(TO_SMP_FAST);
    if (r == 2'h0) v = CNT_W'(TO_SMP_SLOW);
    else if (r == 2'h1) v = CNT_W'(TO_SMP_MID);
    return v;
  endfunction

  function automatic logic [10:0] mul_scale(input logic [10:0] a, input logic [10:0] b);
    logic [21:0] p;
    p = a * b;
    return p[21:11];
  endfunction

  // ----------------------------------------------------------------
  // Dividers: sample tick and microsecond tick
  // ----------------------------------------------------------------
  logic [8:0] smp_cnt_q;
  logic [7:0] us_cnt_q;
  logic smp_tick;
  logic us_tick;

  assign smp_tick = (smp_cnt_q >= sr_div(sample_rate_in));
  assign us_tick = (us_cnt_q == 8'(bbcp_pkg::US_DIV - 1));

  // Sample rate divider, one-cycle enable per sample
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in) smp_cnt_q <= 9'h000;
    else if (smp_tick) smp_cnt_q <= 9'h000;
    else smp_cnt_q <= smp_cnt_q + 9'h001;
  end

  // Microsecond divider for ramp step timing
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in || us_tick) us_cnt_q <= 8'h00;
    else us_cnt_q <= us_cnt_q + 8'h01;
  end

  // ----------------------------------------------------------------
  // PWM sampling, period measure and loss timeout
  // ----------------------------------------------------------------
  logic pwm_s_q;
  logic seen_q;
  logic timeout_q;
  logic start_q;
  logic [CNT_W-1:0] high_q;
  logic [CNT_W-1:0] total_q;
  logic [CNT_W-1:0] idle_q;
  logic [CNT_W-1:0] meas_high_q;
  logic [CNT_W-1:0] meas_total_q;
  logic rise;
  logic pwm_en;

  assign rise = smp_tick && pwm_in && !pwm_s_q;
  assign pwm_en = (mode_in != bbcp_pkg::BBCP_MODE_I2C);

  // Count high and total samples between rising edges; more samples give more bits
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      pwm_s_q <= 1'b0;
      seen_q <= 1'b0;
      start_q <= 1'b0;
      high_q <= '0;
      total_q <= '0;
      meas_high_q <= '0;
      meas_total_q <= '0;
    end
    else
    begin
      start_q <= 1'b0;
      if (smp_tick)
      begin
        pwm_s_q <= pwm_in;
        if (rise)
        begin
          start_q <= seen_q && !timeout_q;
          meas_high_q <= high_q;
          meas_total_q <= total_q;
          high_q <= CNT_ONE;
          total_q <= CNT_ONE;
          seen_q <= 1'b1;
        end
        else
        begin
          if (total_q != CNT_SAT) total_q <= total_q + CNT_ONE;
          if (pwm_in && high_q != CNT_SAT) high_q <= high_q + CNT_ONE;
          if (idle_q >= to_limit(sample_rate_in)) seen_q <= 1'b0;
        end
      end
    end
  end

  // Samples since the last rising edge; the limit follows the sample rate
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      idle_q <= '0;
      timeout_q <= 1'b0;
    end
    else if (smp_tick)
    begin
      if (rise)
      begin
        idle_q <= '0;
        timeout_q <= 1'b0;
      end
      else
      begin
        if (idle_q != CNT_SAT) idle_q <= idle_q + CNT_ONE;
        if (idle_q >= to_limit(sample_rate_in)) timeout_q <= 1'b1;
      end
    end
  end

  logic div_done;
  logic [10:0] duty_code;

  bbcp_duty_div #(
    .CNT_W(CNT_W)
  ) u_div (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .start_in(start_q),
    .high_in(meas_high_q),
    .total_in(meas_total_q),
    .busy_out(),
    .done_out(div_done),
    .code_out(duty_code)
  );

  // ----------------------------------------------------------------
  // Direction-change hysteresis on the duty code
  // ----------------------------------------------------------------
  logic [10:0] pwm_code_q;
  logic dir_up_q;
  logic dup;
  logic [10:0] mag;
  logic [10:0] thr;
  logic [2:0] hsel;

  // Threshold of 2^n codes, setting 7 treated as 6
  always_comb
  begin
    dup = (duty_code > pwm_code_q);
    mag = dup ? duty_code - pwm_code_q : pwm_code_q - duty_code;
    hsel = (hysteresis_in > bbcp_pkg::HYST_MAX) ? bbcp_pkg::HYST_MAX : hysteresis_in;
    thr = 11'h001 << hsel;
  end

  // Reversals must clear the threshold; same direction passes straight through
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      pwm_code_q <= bbcp_pkg::CODE_RESET;
      dir_up_q <= 1'b1;
    end
    else if (timeout_q)
    begin
      pwm_code_q <= bbcp_pkg::CODE_RESET;
      dir_up_q <= 1'b0;
    end
    else if (div_done && duty_code != pwm_code_q)
    begin
      if (dup == dir_up_q || mag >= thr)
      begin
        pwm_code_q <= duty_code;
        dir_up_q <= dup;
      end
    end
  end

  // ----------------------------------------------------------------
  // Brightness word from two writes
  // ----------------------------------------------------------------
  logic [2:0] low_q;
  logic [10:0] word_q;

  // Low bits wait; the word changes only when the high byte lands
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      low_q <= bbcp_pkg::LOW_RESET;
      word_q <= bbcp_pkg::CODE_RESET;
    end
    else
    begin
      if (brightness_low_wr_in) low_q <= brightness_low_in;
      if (brightness_high_wr_in)
      begin
        word_q <= {brightness_high_in, brightness_low_wr_in ? brightness_low_in : low_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode selection and ramper
  // ----------------------------------------------------------------
  localparam int RAMP_US_W_L = bbcp_pkg::RAMP_US_W;
  logic [10:0] target;
  logic [10:0] ramp_q;
  logic [RAMP_US_W_L-1:0] rtim_q;
  logic armed_q;
  logic step;

  // Ramper input per mode
  always_comb
  begin
    case (mode_in)
      bbcp_pkg::BBCP_MODE_I2C: target = word_q;
      bbcp_pkg::BBCP_MODE_PWM: target = pwm_code_q;
      bbcp_pkg::BBCP_MODE_MUL_AFTER: target = word_q;
      default: target = mul_scale(word_q, pwm_code_q);
    endcase
  end

  // First step is immediate, later steps wait one programmed period
  assign step = (ramp_q != target) &&
                (armed_q || (us_tick && rtim_q >= RAMP_US_W_L'(bbcp_pkg::RAMP_US[ramp_rate_in] - 1)));

  // Step timer in microseconds
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in || step || ramp_q == target) rtim_q <= '0;
    else if (us_tick) rtim_q <= rtim_q + RAMP_US_W_L'(1);
  end

  // One code per step toward the target, hold when reached
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      ramp_q <= bbcp_pkg::CODE_RESET;
      armed_q <= 1'b1;
    end
    else
    begin
      armed_q <= (ramp_q == target) || (armed_q && !step);
      if (step) ramp_q <= (target > ramp_q) ? ramp_q + 11'h001 : ramp_q - 11'h001;
    end
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  logic [10:0] code_d;

  assign code_d = (mode_in == bbcp_pkg::BBCP_MODE_MUL_AFTER) ? mul_scale(ramp_q, pwm_code_q) : ramp_q;

  // Registered outputs; code zero turns the LED current off
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      brightness_code_out <= bbcp_pkg::CODE_RESET;
      led_on_out <= 1'b0;
      boost_on_out <= 1'b1;
      pwm_timeout_out <= 1'b0;
      pwm_code_out <= bbcp_pkg::CODE_RESET;
    end
    else
    begin
      brightness_code_out <= code_d;
      led_on_out <= (code_d != 11'h000);
      boost_on_out <= !(pwm_en && timeout_q);
      pwm_timeout_out <= timeout_q;
      pwm_code_out <= pwm_code_q;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  sequence quiet_after_tick;
    ##1 !smp_tick [*8];
  endsequence

  tick_spacing_a: assert property (smp_tick |-> quiet_after_tick)
    else $error("sample ticks too close");
  word_hold_a: assert property (!brightness_high_wr_in |=> $stable(word_q))
    else $error("word changed without high write");
  mode_i2c_a: assert property (mode_in == 2'h0 |-> target == word_q)
    else $error("mode 00 target not the word");
  ramp_unit_a: assert property (!$stable(ramp_q) |-> (ramp_q - $past(ramp_q) == 11'h001 ||
                                $past(ramp_q) - ramp_q == 11'h001))
    else $error("ramp moved by more than one");
  ramp_hold_a: assert property (ramp_q == target && $stable(target) |=> $stable(ramp_q))
    else $error("ramp left its target");
  boost_off_a: assert property (pwm_en && timeout_q |=> !boost_on_out)
    else $error("boost not off on PWM loss");
  hyst_hold_a: assert property (div_done && !timeout_q && dup != dir_up_q && mag < thr |=> $stable(pwm_code_q))
    else $error("reversal below threshold passed");
  same_dir_a: assert property (div_done && !timeout_q && dup == dir_up_q && duty_code != pwm_code_q
                               |=> pwm_code_q == $past(duty_code))
    else $error("same-direction change held");
  led_zero_a: assert property (led_on_out == (brightness_code_out != 11'h000))
    else $error("led on flag disagrees with code");
  timeout_rise_a: assert property ($rose(timeout_q) |-> $past(idle_q) >= to_limit($past(sample_rate_in)))
    else $error("timeout raised early");

endmodule

// ==== tb/bbcp_host_model.sv ====
// Host model: drives the PWM pin and writes the brightness word
`timescale 1ns/1ps
module bbcp_host_model #(
  parameter int PERIOD_CYC = 5120
) (
  // Clock
  input wire logic clock_in,
  // PWM pin
  output logic pwm_out,
  // Brightness word writes
  output logic [2:0] low_out,
  output logic low_wr_out,
  output logic [7:0] high_out,
  output logic high_wr_out
);
  int high_cyc = 0;
  int cur_cyc;
  event period_start;

  // PWM frames of 5120 cycles keep the rate near 48.8 kHz; new duty is taken at frame start
  initial
  begin
    pwm_out = 1'b0;
    low_out = 3'h0;
    low_wr_out = 1'b0;
    high_out = 8'h00;
    high_wr_out = 1'b0;
    forever
    begin
      cur_cyc = high_cyc;
      ->period_start;
      for (int i = 0; i < PERIOD_CYC; i++)
      begin
        @(posedge clock_in);
        pwm_out <= (i < cur_cyc);
      end
    end
  end

  // Low bits alone: stored, data line scrambled once the strobe drops
  task automatic write_low(input logic [2:0] v);
    @(posedge clock_in);
    low_out <= v;
    low_wr_out <= 1'b1;
    @(posedge clock_in);
    low_wr_out <= 1'b0;
    low_out <= ~v;
  endtask

  // High byte: this write is what loads the new word
  task automatic write_high(input logic [7:0] v);
    @(posedge clock_in);
    high_out <= v;
    high_wr_out <= 1'b1;
    @(posedge clock_in);
    high_wr_out <= 1'b0;
    high_out <= ~v;
  endtask

  // Full word: low bits first, then high byte
  task automatic write_word(input logic [10:0] w);
    write_low(w[2:0]);
    write_high(w[10:3]);
  endtask
endmodule

// ==== tb/bbcp_tb_top.sv ====
// Self-checking bench for the backlight brightness code path
`timescale 1ns/1ps
`define CHECK(got, exp, what) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      n_errors++; \
      $display("MISMATCH at %0t: %s got %0h expected %0h", $time, what, got, exp); \
    end \
  end
module bbcp_tb_top;
  localparam int TO_S = 20;
  localparam int TO_M = 100;
  localparam int TO_F = 600;
  localparam int PER_CYC = 5120;
  localparam int DIV_F = bbcp_pkg::SR_DIV_FAST;
  localparam int PER_S = PER_CYC / DIV_F;
  localparam int LIMIT = 200000;
  localparam int TO_T [3] = '{TO_S, TO_M, TO_F};
  localparam int DIV_T [3] = '{bbcp_pkg::SR_DIV_SLOW, bbcp_pkg::SR_DIV_MID, bbcp_pkg::SR_DIV_FAST};

  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [1:0] mode_in = 2'h0;
  logic [1:0] sample_rate_in = 2'h2;
  logic [2:0] hysteresis_in = 3'h0;
  logic [2:0] ramp_rate_in = 3'h0;
  wire pwm;
  wire [2:0] low;
  wire low_wr;
  wire [7:0] high;
  wire high_wr;
  logic [10:0] brightness_code_out;
  logic [10:0] pwm_code_out;
  logic led_on_out;
  logic boost_on_out;
  logic pwm_timeout_out;
  logic [10:0] prev_code = 11'h000;
  logic [31:0] rng = 32'h9b7d;
  int cyc = 0;
  int n_errors = 0;
  int check_count = 0;
  int last_fall = 0;
  bit step_chk = 1'b0;

  bbcp_top #(.TO_SMP_SLOW(TO_S), .TO_SMP_MID(TO_M), .TO_SMP_FAST(TO_F)) u_bbcp_top (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .pwm_in(pwm),
    .brightness_low_in(low), .brightness_low_wr_in(low_wr),
    .brightness_high_in(high), .brightness_high_wr_in(high_wr),
    .mode_in(mode_in), .sample_rate_in(sample_rate_in), .hysteresis_in(hysteresis_in),
    .ramp_rate_in(ramp_rate_in), .brightness_code_out(brightness_code_out),
    .pwm_code_out(pwm_code_out), .led_on_out(led_on_out), .boost_on_out(boost_on_out),
    .pwm_timeout_out(pwm_timeout_out)
  );

  bbcp_host_model #(.PERIOD_CYC(PER_CYC)) u_bbcp_host_model (
    .clock_in(clock_in), .pwm_out(pwm), .low_out(low), .low_wr_out(low_wr),
    .high_out(high), .high_wr_out(high_wr)
  );

  // Clock at 250 MHz
  initial
  begin
    forever #2 clock_in = ~clock_in;
  end

  // Cycle count and hang guard
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_errors++;
      $display("MISMATCH at %0t: run did not finish in time", $time);
      close_out();
    end
  end

  // Ramper output may only move by one code at a time
  always @(posedge clock_in)
  begin
    if (step_chk && brightness_code_out != prev_code)
      `CHECK((brightness_code_out - prev_code == 11'h1) || (prev_code - brightness_code_out == 11'h1), 1'b1, "step")
    prev_code <= brightness_code_out;
  end

  // Time of the last falling PWM edge, reference for the timeout length check (the loss timer starts at the rising edge)
  always @(negedge pwm)
    last_fall = cyc;

  // Random source
  function automatic logic [31:0] xorshift();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  // Duty code for a pulse of hs samples in a 512-sample frame
  function automatic logic [10:0] duty_code(input int hs);
    int c;
    c = hs * 2048 / PER_S;
    return (c > 2047) ? 11'h7ff : c[10:0];
  endfunction

  // Product of two codes kept to its top 11 bits
  function automatic logic [10:0] product(input logic [10:0] a, input logic [10:0] b);
    logic [21:0] p;
    p = a * b;
    return p[21:11];
  endfunction

  task automatic cycles(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic set_cfg(input logic [1:0] m, input logic [1:0] sr, input logic [2:0] hy, input logic [2:0] rr);
    @(posedge clock_in);
    mode_in <= m;
    sample_rate_in <= sr;
    hysteresis_in <= hy;
    ramp_rate_in <= rr;
  endtask

  // New duty, then wait for a full frame at that duty to be measured
  task automatic settle(input int hs);
    u_bbcp_host_model.high_cyc = hs * DIV_F;
    @(u_bbcp_host_model.period_start);
    @(u_bbcp_host_model.period_start);
    cycles(40);
  endtask

  task automatic wait_code(input logic [10:0] exp, output int dt);
    int t0;
    t0 = cyc;
    while (brightness_code_out !== exp && cyc - t0 < 250000)
      @(posedge clock_in);
    #1;
    dt = cyc - t0;
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    int w;
    int d;
    int e;
    int dt;
    int hs;
    int cur;
    repeat (8) @(posedge clock_in);
    reset_n_in <= 1'b1;
    cycles(2);
    `CHECK({brightness_code_out, pwm_code_out, led_on_out, boost_on_out, pwm_timeout_out}, 25'h2, "reset")
    u_bbcp_host_model.high_cyc = (1 + xorshift() % 6) * DIV_F;
    cur = 1 + xorshift() % 7;
    u_bbcp_host_model.write_low(cur[2:0]);
    cycles(20);
    `CHECK(brightness_code_out, 11'h000, "low write alone")
    u_bbcp_host_model.write_high(8'h00);
    wait_code(cur[10:0], dt);
    `CHECK(brightness_code_out, cur[10:0], "word")
    step_chk = 1'b1;
    for (int r = 0; r < 8; r++)
    begin
      d = (r < 5) ? 2 : 1;
      w = (cur < 4) ? cur + d : cur - d;
      e = (d - 1) * bbcp_pkg::RAMP_US[r] * bbcp_pkg::US_DIV;
      set_cfg(2'h0, 2'h2, 3'h0, r[2:0]);
      u_bbcp_host_model.write_word(w[10:0]);
      wait_code(w[10:0], dt);
      `CHECK(brightness_code_out, w[10:0], "ramp end")
      `CHECK(dt + bbcp_pkg::US_DIV + 8 >= e && dt <= e + bbcp_pkg::US_DIV + 8, 1'b1, "ramp time")
      `CHECK({led_on_out, boost_on_out}, 2'h3, "led and boost")
      cur = w;
    end
    hs = 10 + xorshift() % 8;
    set_cfg(2'h1, 2'h2, 3'h3, 3'h0);
    u_bbcp_host_model.write_word(11'h7ff);
    settle(hs);
    `CHECK(pwm_code_out, duty_code(hs), "duty")
    for (int k = 1; k < 4; k++)
    begin
      settle(hs - k);
      `CHECK(pwm_code_out, duty_code(hs - ((k == 1) ? 0 : k)), "hysteresis")
    end
    w = duty_code(hs - 3);
    wait_code(w[10:0], dt);
    `CHECK(brightness_code_out, w[10:0], "pwm only")
    step_chk = 1'b0;
    set_cfg(2'h0, 2'h2, 3'h0, 3'h0);
    u_bbcp_host_model.write_word(w[10:0]);
    settle(PER_S / 2);
    `CHECK({pwm_code_out, brightness_code_out}, {duty_code(PER_S / 2), w[10:0]}, "i2c only")
    set_cfg(2'h2, 2'h2, 3'h0, 3'h0);
    cycles(10);
    `CHECK(brightness_code_out, product(w[10:0], duty_code(PER_S / 2)), "ramp then multiply")
    set_cfg(2'h3, 2'h2, 3'h0, 3'h0);
    cycles(10);
    `CHECK(brightness_code_out, w[10:0] - 11'h1, "multiply then ramp")
    wait_code(product(w[10:0], duty_code(PER_S / 2)), dt);
    `CHECK(brightness_code_out, product(w[10:0], duty_code(PER_S / 2)), "product")
    for (int s = 0; s < 3; s++)
    begin
      set_cfg(2'h1, s[1:0], 3'h0, 3'h0);
      settle(40);
      `CHECK({pwm_timeout_out, boost_on_out}, 2'h1, "pwm running")
      u_bbcp_host_model.high_cyc = 0;
      @(u_bbcp_host_model.period_start);
      for (int n = 0; n < 20000 && pwm_timeout_out !== 1'b1; n++)
        @(posedge clock_in);
      e = TO_T[s] * DIV_T[s];
      dt = cyc - last_fall;
      `CHECK(dt + 420 + 3 * DIV_T[s] >= e && dt <= e + 420 + 3 * DIV_T[s], 1'b1, "timeout length")
      cycles(4);
      `CHECK({pwm_timeout_out, boost_on_out, pwm_code_out}, 13'h1000, "pwm lost")
    end
    set_cfg(2'h0, 2'h2, 3'h0, 3'h0);
    cycles(4);
    `CHECK({pwm_timeout_out, boost_on_out}, 2'h3, "boost kept in i2c mode")
    close_out();
  end
endmodule
